// *** rtl/hpfc_top.sv ***
// Purpose: Host pin control, FET-off pins and pin multiplexing.
// Assumes: One 250 MHz clock; APB slave with no wait states.
// Notes:   FET state survives the reset pin; the rest does not.
`timescale 1ns/10ps
`default_nettype none
module hpfc_top #(
  parameter int HOLD_CYCLES = hpfc_pkg::HOLD_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        rst_shut_pin,
  input  wire logic [5:0]  mf_pin_in,
  input  wire logic        chg_fault,
  input  wire logic        dsg_fault,
  input  wire logic        alarm_level,
  input  wire logic        wire_tx_low,
  input  wire logic [8:0]  otp_ldo,
  input  wire logic        otp_valid,
  output logic [5:0]       mf_pin_out,
  output logic [5:0]       mf_pin_oe,
  output logic [5:0]       mf_pull_up,
  output logic [5:0]       mf_pull_down,
  output logic [5:0]       mf_sup_ldo_a,
  output logic [5:0]       mf_therm_bias,
  output logic [2:0]       ts_bias,
  output logic             charge_fet,
  output logic             precharge_fet,
  output logic             discharge_fet,
  output logic             predischarge_fet,
  output logic             logic_reset,
  output logic             shutdown,
  output logic             ldo_a_en,
  output logic             ldo_b_en,
  output logic             prereg_en,
  output logic [2:0]       ldo_a_vsel,
  output logic [2:0]       ldo_b_vsel,
  output logic [1:0]       comm_mode,
  output logic [3:0]       adc_src,
  output logic [3:0]       adc_chan
);
  logic [1:0]  sync_q;
  logic        rst_pin;
  logic        wire_pin;
  logic        cfet_pin;
  logic        dfet_pin;
  logic [5:0]  ctrl;
  logic [3:0]  fet_req;
  logic [14:0] pinfunc;
  logic [23:0] pindrv;
  logic [8:0]  ldo;
  logic [7:0]  adc;
  logic        loaded;
  logic [31:0] hold_cnt;
  logic        wr_en;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        chg_block;
  logic        dsg_block;
  logic [5:0]  prim_drive;
  logic [5:0]  prim_level;
  logic        wire_seen;
  hpfc_pkg::hpfc_state_t state;

  // The reset pin and the two FET-off pins come from outside the clock.
  hpfc_sync #(.W(2)) u_sync_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({mf_pin_in[hpfc_pkg::PIN_WIRE], rst_shut_pin}),
    .q       (sync_q)
  );
  hpfc_sync #(.W(2)) u_sync_fet (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({mf_pin_in[hpfc_pkg::PIN_DFET],
               mf_pin_in[hpfc_pkg::PIN_CFET]}),
    .q       ({dfet_pin, cfet_pin})
  );
  assign rst_pin  = sync_q[0];
  assign wire_pin = sync_q[1];

  // Reset pin hold timer and shutdown sequencing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= hpfc_pkg::ST_RUN;
      hold_cnt <= 32'h0;
    end else begin
      case (state)
        hpfc_pkg::ST_RUN: begin
          hold_cnt <= 32'h0;
          if (rst_pin) begin
            state <= hpfc_pkg::ST_HELD;
          end
        end
        hpfc_pkg::ST_HELD: begin
          if (!rst_pin) begin
            state <= hpfc_pkg::ST_RUN;
          end else if (hold_cnt >= 32'(HOLD_CYCLES - 2)) begin
            state <= hpfc_pkg::ST_OFF;
          end else begin
            hold_cnt <= hold_cnt + 32'h1;
          end
        end
        hpfc_pkg::ST_OFF: begin
          // Only a power-on reset leaves shutdown.
          state <= hpfc_pkg::ST_OFF;
        end
        default: begin
          state <= hpfc_pkg::ST_RUN;
        end
      endcase
    end
  end

  // APB write strobe; blocked while the reset pin is high.
  assign wr_en = psel && penable && pwrite && pready && !rst_pin;

  // Configuration registers, all cleared by the reset pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= hpfc_pkg::CTRL_RESET;
      pinfunc <= 15'h0;
      pindrv  <= 24'h0;
      adc     <= hpfc_pkg::ADC_RESET;
    end else if (rst_pin) begin
      ctrl    <= hpfc_pkg::CTRL_RESET;
      pinfunc <= 15'h0;
      pindrv  <= 24'h0;
      adc     <= hpfc_pkg::ADC_RESET;
    end else if (wr_en) begin
      if (paddr == hpfc_pkg::ADDR_CTRL) begin
        // An unused serial mode code drops the whole control write, so every field keeps its value.
        if (pwdata[5:4] != 2'h3) begin
          ctrl <= pwdata[5:0];
        end
      end else if (paddr == hpfc_pkg::ADDR_PINFUNC) begin
        pinfunc <= pwdata[14:0];
      end else if (paddr == hpfc_pkg::ADDR_PINDRV) begin
        pindrv <= pwdata[23:0];
      end else if (paddr == hpfc_pkg::ADDR_ADC) begin
        if (pwdata[3:0] <= hpfc_pkg::ADC_LOAD) begin
          adc <= pwdata[7:0];
        end
      end
    end
  end

  // Host FET requests hold FET state, so the reset pin leaves them alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fet_req <= 4'h0;
    end else if (wr_en && paddr == hpfc_pkg::ADDR_FET) begin
      fet_req <= pwdata[3:0];
    end
  end

  // Regulator settings load from stored memory before the bus answers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ldo    <= hpfc_pkg::LDO_RESET;
      loaded <= 1'b0;
    end else if (rst_pin) begin
      loaded <= 1'b0;
    end else if (!loaded) begin
      ldo    <= otp_valid ? otp_ldo : hpfc_pkg::LDO_RESET;
      loaded <= 1'b1;
    end else if (wr_en && paddr == hpfc_pkg::ADDR_LDO) begin
      if (pwdata[5:3] <= hpfc_pkg::VSEL_5V0) begin
        ldo[5:0] <= pwdata[5:0];
      end else begin
        ldo[2:0] <= pwdata[2:0];
      end
      if (pwdata[8:6] <= hpfc_pkg::VSEL_5V0) begin
        ldo[8:6] <= pwdata[8:6];
      end
    end
  end

  // Read mux and address decode.
  always_comb begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    if (paddr == hpfc_pkg::ADDR_CTRL) begin
      rd_val[5:0] = ctrl;
    end else if (paddr == hpfc_pkg::ADDR_FET) begin
      rd_val[3:0] = fet_req;
    end else if (paddr == hpfc_pkg::ADDR_PINFUNC) begin
      rd_val[14:0] = pinfunc;
    end else if (paddr == hpfc_pkg::ADDR_PINDRV) begin
      rd_val[23:0] = pindrv;
    end else if (paddr == hpfc_pkg::ADDR_LDO) begin
      rd_val[8:0] = ldo;
    end else if (paddr == hpfc_pkg::ADDR_ADC) begin
      rd_val[7:0] = adc;
    end else if (paddr == hpfc_pkg::ADDR_STATUS) begin
      rd_val[11:0] = {wire_seen, loaded, state == hpfc_pkg::ST_OFF,
                      predischarge_fet, discharge_fet,
                      precharge_fet, charge_fet, dsg_fault,
                      chg_fault, dfet_pin, cfet_pin, rst_pin};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // No wait states; no answer until stored settings are in place.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable && loaded;
      pslverr <= psel && !penable && !rd_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_ok ? rd_val : 32'h0;
      end
    end
  end

  // Blockers per FET path. Faults only block in standalone mode.
  always_comb begin
    chg_block = !fet_req[0] || state == hpfc_pkg::ST_OFF;
    dsg_block = !fet_req[2] || state == hpfc_pkg::ST_OFF;
    if (!ctrl[hpfc_pkg::CTRL_MANUAL]) begin
      chg_block = chg_block || chg_fault;
      dsg_block = dsg_block || dsg_fault;
    end
    if (ctrl[hpfc_pkg::CTRL_CPIN_EN] && !ctrl[hpfc_pkg::CTRL_BOTH_FETS_OFF_FUNCTION] &&
        pinfunc[3:2] == hpfc_pkg::FN_PRIMARY) begin
      chg_block = chg_block || cfet_pin;
    end
    if (ctrl[hpfc_pkg::CTRL_DPIN_EN] &&
        pinfunc[5:4] == hpfc_pkg::FN_PRIMARY) begin
      dsg_block = dsg_block || dfet_pin;
      if (ctrl[hpfc_pkg::CTRL_BOTH_FETS_OFF_FUNCTION]) begin
        chg_block = chg_block || dfet_pin;
      end
    end
  end

  // FET drivers; only a power-on reset clears them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_fet       <= 1'b0;
      precharge_fet    <= 1'b0;
      discharge_fet    <= 1'b0;
      predischarge_fet <= 1'b0;
    end else begin
      charge_fet       <= !chg_block;
      precharge_fet    <= !chg_block && fet_req[1];
      discharge_fet    <= !dsg_block;
      predischarge_fet <= !dsg_block && fet_req[3];
    end
  end

  // Primary levels of pins that drive in their own function.
  always_comb begin
    prim_drive = 6'h0;
    prim_level = 6'h0;
    prim_drive[hpfc_pkg::PIN_ALERT] = 1'b1;
    prim_level[hpfc_pkg::PIN_ALERT] = alarm_level;
    // Single-wire mode is open drain: drive only the low level.
    prim_drive[hpfc_pkg::PIN_WIRE] = (comm_mode == hpfc_pkg::COMM_WIRE) &&
                                     wire_tx_low;
    prim_drive[hpfc_pkg::PIN_CHARGE_FAULT_OUTPUT] = 1'b1;
    prim_level[hpfc_pkg::PIN_CHARGE_FAULT_OUTPUT] = chg_fault;
    prim_drive[hpfc_pkg::PIN_DISCHARGE_FAULT_OUTPUT] = 1'b1;
    prim_level[hpfc_pkg::PIN_DISCHARGE_FAULT_OUTPUT] = dsg_fault;
  end

  genvar gi;
  generate
    for (gi = 0; gi < hpfc_pkg::NPIN; gi = gi + 1) begin : g_pin
      hpfc_pin_drv u_drv (
        .pclk       (pclk),
        .presetn    (presetn),
        .func       (pinfunc[2*gi +: 2]),
        .gpo_level  (pindrv[hpfc_pkg::DRV_GPO_LSB + gi]),
        .prim_drive (prim_drive[gi]),
        .prim_level (prim_level[gi]),
        .sup_sel    (pindrv[hpfc_pkg::DRV_SUP_LSB + gi]),
        .pull       (pindrv[hpfc_pkg::DRV_PULL_LSB + 2*gi +: 2]),
        .pin_out    (mf_pin_out[gi]),
        .pin_oe     (mf_pin_oe[gi]),
        .pull_up    (mf_pull_up[gi]),
        .pull_down  (mf_pull_down[gi]),
        .sup_ldo_a  (mf_sup_ldo_a[gi]),
        .therm_bias (mf_therm_bias[gi])
      );
    end
  endgenerate

  // Supply, bus mode and converter outputs. Shutdown drops every supply.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      logic_reset <= 1'b0;
      shutdown    <= 1'b0;
      ldo_a_en    <= 1'b0;
      ldo_b_en    <= 1'b0;
      prereg_en   <= 1'b0;
      ldo_a_vsel  <= hpfc_pkg::VSEL_1V8;
      ldo_b_vsel  <= hpfc_pkg::VSEL_1V8;
      comm_mode   <= hpfc_pkg::COMM_I2C;
      adc_src     <= hpfc_pkg::ADC_GND;
      adc_chan    <= 4'h0;
      ts_bias     <= 3'h0;
    end else begin
      logic_reset <= rst_pin;
      shutdown    <= state == hpfc_pkg::ST_OFF;
      ldo_a_en    <= ldo[hpfc_pkg::LDO_A_EN] && state != hpfc_pkg::ST_OFF;
      ldo_b_en    <= ldo[hpfc_pkg::LDO_B_EN] && state != hpfc_pkg::ST_OFF;
      prereg_en   <= ldo[hpfc_pkg::PREREG_EN] && state != hpfc_pkg::ST_OFF;
      ldo_a_vsel  <= ldo[hpfc_pkg::VSEL_A_LSB +: 3];
      ldo_b_vsel  <= ldo[hpfc_pkg::VSEL_B_LSB +: 3];
      comm_mode   <= ctrl[hpfc_pkg::CTRL_COMM_LSB +: 2];
      adc_src     <= adc[3:0];
      adc_chan    <= adc[7:4];
      ts_bias     <= pinfunc[14:12];
    end
  end

  // Single-wire receive level is sampled but handled by the bus engine.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wire_seen <= 1'b0;
    end else begin
      wire_seen <= wire_pin && comm_mode == hpfc_pkg::COMM_WIRE;
    end
  end

  reset_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_pin |=> ctrl == hpfc_pkg::CTRL_RESET && !loaded)
    else $error("reset pin did not clear configuration");

  fet_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_pin && !$past(wr_en) && state != hpfc_pkg::ST_OFF
    |-> $stable(fet_req))
    else $error("reset pin changed FET state");

  hold_shut_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == hpfc_pkg::ST_OFF) |-> hold_cnt == 32'(HOLD_CYCLES - 2)
    && $past(rst_pin))
    else $error("shutdown entered before the hold time");

  shut_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == hpfc_pkg::ST_OFF |-> ##2 !charge_fet && !discharge_fet
    && !ldo_a_en && !ldo_b_en && !prereg_en)
    else $error("shutdown left a FET or supply on");

  chg_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfet_pin && ctrl[2] && !ctrl[1] && pinfunc[3:2] == 2'h0
    |=> !charge_fet && !precharge_fet)
    else $error("charge-off pin did not disable charge FETs");

  dsg_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    dfet_pin && ctrl[3] && pinfunc[5:4] == 2'h0
    |=> !discharge_fet && !predischarge_fet)
    else $error("discharge-off pin did not disable discharge FETs");

  both_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    dfet_pin && ctrl[3] && ctrl[1] && pinfunc[5:4] == 2'h0
    |=> !charge_fet && !discharge_fet)
    else $error("both-off did not disable all FETs");

  host_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    !fet_req[0] |=> !charge_fet)
    else $error("charge FET on while host blocks it");

  fault_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    pinfunc[9:8] == 2'h0 |=> mf_pin_out[4] == $past(chg_fault))
    else $error("charge fault pin does not follow the fault");

  discharge_fault_output_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    pinfunc[11:10] == 2'h0 |=> mf_pin_out[5] == $past(dsg_fault))
    else $error("discharge fault pin does not follow the fault");

  manual_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[0] && fet_req[0] && !cfet_pin && !dfet_pin
    && state == hpfc_pkg::ST_RUN
    ##1 ctrl[0] && fet_req[0] && !cfet_pin && !dfet_pin
    && state == hpfc_pkg::ST_RUN
    |=> charge_fet)
    else $error("manual mode let a fault switch a FET");

  vsel_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    ldo_a_vsel <= 3'h4 && ldo_b_vsel <= 3'h4)
    else $error("regulator voltage outside the five settings");

  no_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    !loaded |=> !pready)
    else $error("bus answered before stored settings loaded");
endmodule
`default_nettype wire

// *** pkg/hpfc_pkg.sv ***
// Purpose: Constants and types for the host pin and FET-off control block.
// Assumes: APB register access with 32-bit data, word aligned offsets.
// Notes:   Every offset and the hold time live here; some field positions and reset values are literals in hpfc_top.
package hpfc_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_FET     = 8'h04;
  localparam logic [7:0] ADDR_PINFUNC = 8'h08;
  localparam logic [7:0] ADDR_PINDRV  = 8'h0c;
  localparam logic [7:0] ADDR_LDO     = 8'h10;
  localparam logic [7:0] ADDR_ADC     = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  // Control register fields.
  localparam int CTRL_MANUAL   = 0;
  localparam int CTRL_BOTH_FETS_OFF_FUNCTION  = 1;
  localparam int CTRL_CPIN_EN  = 2;
  localparam int CTRL_DPIN_EN  = 3;
  localparam int CTRL_COMM_LSB = 4;
  localparam logic [5:0] CTRL_RESET = 6'h0c;
  // Serial bus modes.
  localparam logic [1:0] COMM_I2C  = 2'h0;
  localparam logic [1:0] COMM_SPI  = 2'h1;
  localparam logic [1:0] COMM_WIRE = 2'h2;
  // Multifunction pin indices.
  localparam int NPIN      = 6;
  localparam int PIN_ALERT = 0;
  localparam int PIN_CFET  = 1;
  localparam int PIN_DFET  = 2;
  localparam int PIN_WIRE  = 3;
  localparam int PIN_CHARGE_FAULT_OUTPUT  = 4;
  localparam int PIN_DISCHARGE_FAULT_OUTPUT  = 5;
  // Pin functions, two bits per pin.
  localparam logic [1:0] FN_PRIMARY = 2'h0;
  localparam logic [1:0] FN_GPO     = 2'h1;
  localparam logic [1:0] FN_THERM   = 2'h2;
  localparam logic [1:0] FN_ADC     = 2'h3;
  // Weak pulls, two bits per pin.
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;
  // Drive and pull register fields.
  localparam int DRV_GPO_LSB  = 0;
  localparam int DRV_SUP_LSB  = 6;
  localparam int DRV_PULL_LSB = 12;
  // Regulator register fields and output settings.
  localparam int LDO_A_EN   = 0;
  localparam int LDO_B_EN   = 1;
  localparam int PREREG_EN  = 2;
  localparam int VSEL_A_LSB = 3;
  localparam int VSEL_B_LSB = 6;
  localparam logic [2:0] VSEL_1V8 = 3'h0;
  localparam logic [2:0] VSEL_5V0 = 3'h4;
  localparam logic [8:0] LDO_RESET = 9'h000;
  // Voltage converter input sources.
  localparam logic [3:0] ADC_CELL   = 4'h0;
  localparam logic [3:0] ADC_TEMP   = 4'h1;
  localparam logic [3:0] ADC_THERM  = 4'h2;
  localparam logic [3:0] ADC_CORE   = 4'h3;
  localparam logic [3:0] ADC_GND    = 4'h4;
  localparam logic [3:0] ADC_TOPDIV = 4'h5;
  localparam logic [3:0] ADC_PACK   = 4'h6;
  localparam logic [3:0] ADC_LOAD   = 4'h7;
  localparam logic [7:0] ADC_RESET  = 8'h04;
  // Shutdown hold time.
  localparam int HOLD_MS  = 1000;
  localparam int CLK_KHZ  = 250000;
  localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_HELD = 3'b010,
    ST_OFF  = 3'b100
  } hpfc_state_t;
endpackage

// *** rtl/hpfc_sync.sv ***
// Purpose: Two flip-flop synchroniser for pin levels.
// Assumes: Inputs are slow levels from outside the clock domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module hpfc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// *** rtl/hpfc_pin_drv.sv ***
// Purpose: Output stage of one multifunction pin.
// Assumes: Configuration and primary level come from the same clock.
// Notes:   Outputs are registered so the pin never glitches.
`timescale 1ns/10ps
`default_nettype none
module hpfc_pin_drv (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] func,
  input  wire logic       gpo_level,
  input  wire logic       prim_drive,
  input  wire logic       prim_level,
  input  wire logic       sup_sel,
  input  wire logic [1:0] pull,
  output logic            pin_out,
  output logic            pin_oe,
  output logic            pull_up,
  output logic            pull_down,
  output logic            sup_ldo_a,
  output logic            therm_bias
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out    <= 1'b0;
      pin_oe     <= 1'b0;
      pull_up    <= 1'b0;
      pull_down  <= 1'b0;
      sup_ldo_a  <= 1'b0;
      therm_bias <= 1'b0;
    end else begin
      pin_out    <= (func == hpfc_pkg::FN_GPO) ? gpo_level
                                               : prim_level;
      pin_oe     <= (func == hpfc_pkg::FN_GPO) ||
                    (func == hpfc_pkg::FN_PRIMARY && prim_drive);
      pull_up    <= (pull == hpfc_pkg::PULL_UP);
      pull_down  <= (pull == hpfc_pkg::PULL_DOWN);
      sup_ldo_a  <= sup_sel;
      therm_bias <= (func == hpfc_pkg::FN_THERM);
    end
  end
endmodule
`default_nettype wire

// *** verif/hpfc_host_model.sv ***
// Purpose: Host side model driving the reset pin and both FET-off pins.
// Assumes: Commands come from the bench just after rising clock edges.
// Notes:   An undriven pin with no pull shows the inverse of its last level.
`timescale 1ns/10ps
`default_nettype none
module hpfc_host_model (
  input  wire logic       pclk,
  input  wire logic       want_rst,
  input  wire logic [1:0] want_off,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pull_up,
  input  wire logic [5:0] pull_down,
  output logic            rst_pin,
  output logic [5:0]      pin_lvl
);
  initial begin
    rst_pin = 1'b0;
    pin_lvl = 6'h00;
  end
  always @(posedge pclk) begin
    rst_pin <= want_rst;
    for (int i = 0; i < 6; i++) begin
      if (i == 1 || i == 2) pin_lvl[i] <= want_off[i-1];
      else if (pin_oe[i]) pin_lvl[i] <= pin_out[i];
      else if (pull_up[i]) pin_lvl[i] <= 1'b1;
      else if (pull_down[i]) pin_lvl[i] <= 1'b0;
      else pin_lvl[i] <= ~pin_lvl[i];
    end
  end
endmodule
`default_nettype wire

// *** verif/test_host_pin_fet_off_control.sv ***
// Purpose: Self-checking bench for the host pin and FET-off block.
// Assumes: A short hold count so shutdown is reached in a few cycles.
// Notes:   Every check is a register read compared against a queued note.
`timescale 1ns/10ps
`default_nettype none
module test_host_pin_fet_off_control;
  localparam int HOLD = 20;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        want_rst = 1'b0;
  logic [1:0]  want_off = 2'h0;
  logic        chg_fault = 1'b0;
  logic        dsg_fault = 1'b0;
  logic        otp_valid = 1'b0;
  logic [8:0]  otp_ldo = 9'h000;
  logic        rst_pin;
  logic [5:0]  pin_lvl, pin_out, pin_oe, pull_up, pull_down;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          err_total = 0;
  int          check_count = 0;
  logic [2:0]  va, vb;
  logic [3:0]  ch;
  always #2 pclk = ~pclk;
  hpfc_top #(.HOLD_CYCLES(HOLD)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .rst_shut_pin(rst_pin), .mf_pin_in(pin_lvl),
    .chg_fault, .dsg_fault, .alarm_level(1'b0), .wire_tx_low(1'b0),
    .otp_ldo, .otp_valid, .mf_pin_out(pin_out), .mf_pin_oe(pin_oe),
    .mf_pull_up(pull_up), .mf_pull_down(pull_down), .mf_sup_ldo_a(),
    .mf_therm_bias(), .ts_bias(), .charge_fet(), .precharge_fet(),
    .discharge_fet(), .predischarge_fet(), .logic_reset(), .shutdown(),
    .ldo_a_en(), .ldo_b_en(), .prereg_en(), .ldo_a_vsel(), .ldo_b_vsel(),
    .comm_mode(), .adc_src(), .adc_chan());
  hpfc_host_model host_u (.pclk, .want_rst, .want_off, .pin_out, .pin_oe,
    .pull_up, .pull_down, .rst_pin, .pin_lvl);
  task automatic wrap_up();
    $display("Counts: errors=%0d checks=%0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    if (!w) begin
      exp_q.push_back({e, d & m});
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    apb(1'b0, a, d, m, 1'b0);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check_count++;
      if ({pslverr, prdata & msk_q[0]} !== exp_q[0]) begin
        $display("BAD t=%0t exp=%h got=%h", $time, exp_q[0],
                 {pslverr, prdata & msk_q[0]});
        err_total++;
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    void'($urandom(50575));
    tick(8);
    presetn <= 1'b1;
    rd(hpfc_pkg::ADDR_CTRL, 32'hc, '1);
    rd(hpfc_pkg::ADDR_ADC, 32'h4, '1);
    rd(hpfc_pkg::ADDR_LDO, 32'h0, '1);
    apb(1'b0, 8'h1c, 32'h0, '1, 1'b1);
    wr(hpfc_pkg::ADDR_FET, 32'hf);
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h1e0, 32'h3e0);
    chg_fault <= 1'b1;
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h80, 32'ha0);
    wr(hpfc_pkg::ADDR_CTRL, 32'hd);
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'ha0, 32'ha0);
    dsg_fault <= 1'b1;
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h1f8, 32'h1f8);
    chg_fault <= 1'b0;
    wr(hpfc_pkg::ADDR_CTRL, 32'hc);
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h070, 32'h1f8);
    dsg_fault <= 1'b0;
    want_off <= 2'b01;
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h180, 32'h1e0);
    want_off <= 2'b10;
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h060, 32'h1e0);
    wr(hpfc_pkg::ADDR_FET, 32'h3);
    want_off <= 2'b00;
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h060, 32'h1e0);
    wr(hpfc_pkg::ADDR_FET, 32'hf);
    wr(hpfc_pkg::ADDR_CTRL, 32'he);
    want_off <= 2'b10;
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h000, 32'h1e0);
    want_off <= 2'b01;
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h1e0, 32'h1e0);
    wr(hpfc_pkg::ADDR_CTRL, 32'h8);
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h1e0, 32'h1e0);
    want_off <= 2'b00;
    for (int m = 0; m < 4; m++) begin
      wr(hpfc_pkg::ADDR_CTRL, 32'hc | (m << 4));
      rd(hpfc_pkg::ADDR_CTRL, m < 3 ? 32'hc | (m << 4) : 32'h2c, '1);
    end
    for (int s = 0; s < 8; s++) begin
      ch = 4'($urandom);
      wr(hpfc_pkg::ADDR_ADC, {24'h0, ch, 4'(s)});
      rd(hpfc_pkg::ADDR_ADC, {24'h0, ch, 4'(s)}, '1);
    end
    wr(hpfc_pkg::ADDR_ADC, 32'hf9);
    rd(hpfc_pkg::ADDR_ADC, {24'h0, ch, 4'h7}, '1);
    va = 3'($urandom_range(4));
    vb = 3'($urandom_range(4));
    wr(hpfc_pkg::ADDR_LDO, {23'h0, vb, va, 3'h5});
    wr(hpfc_pkg::ADDR_LDO, {23'h0, 3'h5, va, 3'h5});
    rd(hpfc_pkg::ADDR_LDO, {23'h0, vb, va, 3'h5}, '1);
    wr(hpfc_pkg::ADDR_PINFUNC, 32'h1);
    wr(hpfc_pkg::ADDR_PINDRV, 32'h800041);
    rd(hpfc_pkg::ADDR_PINFUNC, 32'h1, '1);
    rd(hpfc_pkg::ADDR_PINDRV, 32'h800041, '1);
    want_rst <= 1'b1;
    tick(6);
    want_rst <= 1'b0;
    tick(4);
    rd(hpfc_pkg::ADDR_CTRL, 32'hc, '1);
    rd(hpfc_pkg::ADDR_PINDRV, 32'h0, '1);
    rd(hpfc_pkg::ADDR_STATUS, 32'h1e0, 32'h3e0);
    want_rst <= 1'b1;
    tick(HOLD + 6);
    want_rst <= 1'b0;
    tick(4);
    rd(hpfc_pkg::ADDR_STATUS, 32'h200, 32'h3e0);
    otp_ldo   <= 9'h08f;
    otp_valid <= 1'b1;
    presetn   <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    rd(hpfc_pkg::ADDR_LDO, 32'h8f, '1);
    wrap_up();
  end
endmodule
`default_nettype wire
